// >>> inc/ch1_timer_pkg.sv
// Package: register map, field positions, reset values and carriers of the channel-1 B block
package ch1_timer_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] IO_CTL_OFS = 8'h00;
    localparam logic [7:0] IRQ_EN_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0C;
    localparam logic [7:0] GRB_OFS = 8'h10;

    // Field positions inside io_control_reg
    localparam int B_CTL_BIT3_POS = 7;
    localparam int B_CTL_BIT2_POS = 6;
    localparam int B_CTL_BIT1_POS = 5;
    localparam int B_CTL_BIT0_POS = 4;

    // Field positions of the enable, status and mask words
    localparam int IRQ_EN_A_POS = 0;
    localparam int IRQ_EN_B_POS = 1;
    localparam int IRQ_EN_C_POS = 2;
    localparam int FLAG_A_POS = 0;
    localparam int FLAG_B_POS = 1;

    // Output compare actions in the two low bits of the B field
    localparam logic [1:0] OC_RETAIN = 2'h0;
    localparam logic [1:0] OC_LOW = 2'h1;
    localparam logic [1:0] OC_HIGH = 2'h2;
    localparam logic [1:0] OC_TOGGLE = 2'h3;

    // Reset values
    localparam logic [7:0] IO_CTL_RST = 8'h00;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [15:0] GRB_RST = 16'hFFFF;
    localparam logic PIN_RST = 1'b0;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Whole state of the channel block
    typedef struct packed {
        wb_rsp_t rsp;
        logic [7:0] io_ctl;
        logic [1:0] irq_en;
        logic [1:0] status;
        logic [1:0] mask;
        logic [15:0] grb;
        logic pin_out;
        logic pin_oe_n;
        logic eq_prev;
        logic irq;
        logic req_a;
        logic req_b;
        logic req_c;
    } ch1_state_t;

    // State of the pin synchroniser
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } edge_state_t;

endpackage

// >>> logic/pin_edge_detect.sv
// Two-stage synchroniser and edge detector for the channel pin
`timescale 1ns/1ns
module pin_edge_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous pin level
    input wire logic pin_async,
    // Edge pulses, one cycle each
    output logic rise,
    output logic fall
);
    ch1_timer_pkg::edge_state_t st_reg;
    ch1_timer_pkg::edge_state_t st_next;

    // Only the second stage feeds the edge logic, never the first
    always_comb begin
        st_next = st_reg;
        st_next.meta = pin_async;
        st_next.sync = st_reg.meta;
        st_next.last = st_reg.sync;
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Edges seen between the second and third stage
    assign rise = st_reg.sync & ~st_reg.last;
    assign fall = ~st_reg.sync & st_reg.last;
endmodule // pin_edge_detect

// >>> logic/ch1_b_channel.sv
// Timer channel 1, general register B: compare output, capture and interrupt enables
`timescale 1ns/1ns
// Contract
// - Top field bit clear: compare mode; bit 6 gives initial level unless low bits are 00; 01 drives 0.
// - Compare mode with low bits 10 drives the pin high on match.
// - Compare mode with low bits 11 inverts the pin on every match.
// - Pin is 0 after reset; low bits 00 keep the level on match.
// - Field 1000 captures the counter into register B on a rising pin edge.
// - Field 1001 captures the counter on a falling pin edge.
// - Field 101x captures on both pin edges; bit 4 ignored.
// - Field 11xx captures on each channel-0 C register event.
// - A request raised only while flag A set and enable bit 0 set.
// - B request raised only while flag B set and enable bit 1 set.
// - Enable bit 2 reserved here: reads 0, C request never raised.
module ch1_b_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire ch1_timer_pkg::wb_req_t wb_req,
    output ch1_timer_pkg::wb_rsp_t wb_rsp,
    // Timer core
    input wire logic [15:0] counter_value,
    input wire logic ch0_c_event,
    input wire logic flag_a_event,
    // Channel pin
    input wire logic ch1_b_pin_in,
    output logic ch1_b_pin_out,
    output logic ch1_b_pin_oe_n,
    // Interrupts
    output logic irq,
    output logic irq_req_a,
    output logic irq_req_b,
    output logic irq_req_c
);
    ch1_timer_pkg::ch1_state_t st_reg;
    ch1_timer_pkg::ch1_state_t st_next;
    logic pin_rise;
    logic pin_fall;
    logic bus_acc;
    logic bus_wr;
    logic io_wr;
    logic cap_mode;
    logic [1:0] oc_act;
    logic cnt_eq;
    logic match_ev;
    logic cap_ev;
    logic b_event;
    logic [1:0] st_clr;
    logic [31:0] rd_word;

    // Pin edges, synchronised first since the pin is outside our clock
    pin_edge_detect u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_async(ch1_b_pin_in),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Bus decode: one access per request, the ack cycle blocks a second one
    assign bus_acc = wb_req.cyc & wb_req.stb & ~st_reg.rsp.ack;
    assign bus_wr = bus_acc & wb_req.we & wb_req.sel[0];
    assign io_wr = bus_wr & (wb_req.adr == ch1_timer_pkg::IO_CTL_OFS);

    // Mode decode of the B field
    assign cap_mode = st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT3_POS];
    assign oc_act = {st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT1_POS],
                     st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT0_POS]};

    // Match only on the cycle the counter reaches register B, not while it sits there
    assign cnt_eq = (counter_value == st_reg.grb);
    assign match_ev = ~cap_mode & cnt_eq & ~st_reg.eq_prev;

    // Capture source select
    always_comb begin
        cap_ev = 1'b0;
        if (cap_mode) begin
            if (st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT2_POS]) begin
                cap_ev = ch0_c_event;
            end else if (st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT1_POS]) begin
                cap_ev = pin_rise | pin_fall;
            end else if (st_reg.io_ctl[ch1_timer_pkg::B_CTL_BIT0_POS]) begin
                cap_ev = pin_fall;
            end else begin
                cap_ev = pin_rise;
            end
        end
    end

    // A match with action 00 is not an event worth flagging? It still is a match.
    assign b_event = match_ev | cap_ev;

    // Write-one-to-clear mask for the status word
    assign st_clr = (bus_wr && wb_req.adr == ch1_timer_pkg::STATUS_OFS) ?
                    wb_req.dat[1:0] : 2'h0;

    // Read multiplexer; unmapped offsets read zero and still get an ack
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_req.adr)
            ch1_timer_pkg::IO_CTL_OFS: rd_word = {24'h000000, st_reg.io_ctl};
            ch1_timer_pkg::IRQ_EN_OFS: rd_word = {29'h0, 1'b0, st_reg.irq_en};
            ch1_timer_pkg::STATUS_OFS: rd_word = {30'h0, st_reg.status};
            ch1_timer_pkg::MASK_OFS: rd_word = {30'h0, st_reg.mask};
            ch1_timer_pkg::GRB_OFS: rd_word = {16'h0000, st_reg.grb};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rsp.ack = bus_acc;
        st_next.rsp.dat = (bus_acc && !wb_req.we) ? rd_word : 32'h0000_0000;
        st_next.eq_prev = cnt_eq;

        // Register writes, low byte lane; high byte of register B on lane 1
        if (bus_wr) begin
            case (wb_req.adr)
                ch1_timer_pkg::IO_CTL_OFS: st_next.io_ctl = wb_req.dat[7:0];
                ch1_timer_pkg::IRQ_EN_OFS: st_next.irq_en = wb_req.dat[1:0];
                ch1_timer_pkg::MASK_OFS: st_next.mask = wb_req.dat[1:0];
                ch1_timer_pkg::GRB_OFS: st_next.grb[7:0] = wb_req.dat[7:0];
                default: st_next.mask = st_reg.mask;
            endcase
        end
        if (bus_acc && wb_req.we && wb_req.sel[1] && wb_req.adr == ch1_timer_pkg::GRB_OFS) begin
            st_next.grb[15:8] = wb_req.dat[15:8];
        end

        // Capture beats a software write of register B in the same cycle
        if (cap_ev) begin
            st_next.grb = counter_value;
        end

        // Compare output actions
        if (match_ev) begin
            case (oc_act)
                ch1_timer_pkg::OC_LOW: st_next.pin_out = 1'b0;
                ch1_timer_pkg::OC_HIGH: st_next.pin_out = 1'b1;
                ch1_timer_pkg::OC_TOGGLE: st_next.pin_out = ~st_reg.pin_out;
                default: st_next.pin_out = st_reg.pin_out;
            endcase
        end

        // A compare-mode write sets the initial level (keeps it for low bits 00) and wins over a match; a capture-mode write leaves the match action in place
        if (io_wr) begin
            if (!wb_req.dat[ch1_timer_pkg::B_CTL_BIT3_POS] &&
                wb_req.dat[ch1_timer_pkg::B_CTL_BIT1_POS +: 0 + 1] == 1'b0 &&
                !wb_req.dat[ch1_timer_pkg::B_CTL_BIT0_POS]) begin
                st_next.pin_out = st_reg.pin_out;
            end else if (!wb_req.dat[ch1_timer_pkg::B_CTL_BIT3_POS]) begin
                st_next.pin_out = wb_req.dat[ch1_timer_pkg::B_CTL_BIT2_POS];
            end
            st_next.pin_oe_n = wb_req.dat[ch1_timer_pkg::B_CTL_BIT3_POS];
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        st_next.status[ch1_timer_pkg::FLAG_A_POS] =
            (st_reg.status[ch1_timer_pkg::FLAG_A_POS] & ~st_clr[0]) | flag_a_event;
        st_next.status[ch1_timer_pkg::FLAG_B_POS] =
            (st_reg.status[ch1_timer_pkg::FLAG_B_POS] & ~st_clr[1]) | b_event;

        // Gated requests follow the flags one cycle behind
        st_next.req_a = st_reg.status[ch1_timer_pkg::FLAG_A_POS] &
                        st_reg.irq_en[ch1_timer_pkg::IRQ_EN_A_POS];
        st_next.req_b = st_reg.status[ch1_timer_pkg::FLAG_B_POS] &
                        st_reg.irq_en[ch1_timer_pkg::IRQ_EN_B_POS];
        st_next.req_c = 1'b0;
        st_next.irq = |(st_reg.status & st_reg.mask);
    end

    // State register; pin driven low from reset on
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg.rsp <= '0;
            st_reg.io_ctl <= ch1_timer_pkg::IO_CTL_RST;
            st_reg.irq_en <= ch1_timer_pkg::IRQ_EN_RST;
            st_reg.status <= ch1_timer_pkg::STATUS_RST;
            st_reg.mask <= ch1_timer_pkg::MASK_RST;
            st_reg.grb <= ch1_timer_pkg::GRB_RST;
            st_reg.pin_out <= ch1_timer_pkg::PIN_RST;
            st_reg.pin_oe_n <= 1'b0;
            st_reg.eq_prev <= 1'b0;
            st_reg.irq <= 1'b0;
            st_reg.req_a <= 1'b0;
            st_reg.req_b <= 1'b0;
            st_reg.req_c <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign wb_rsp = st_reg.rsp;
    assign ch1_b_pin_out = st_reg.pin_out;
    assign ch1_b_pin_oe_n = st_reg.pin_oe_n;
    assign irq = st_reg.irq;
    assign irq_req_a = st_reg.req_a;
    assign irq_req_b = st_reg.req_b;
    assign irq_req_c = st_reg.req_c;

    // Checks on the logic above
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_match(logic [1:0] act);
        match_ev && oc_act == act && !io_wr;
    endsequence

    sequence s_cap_cfg(logic [3:0] fld);
        cap_ev && st_reg.io_ctl[7:4] == fld;
    endsequence

    AST_MATCH_LOW: assert property (s_match(2'h1) |=> !ch1_b_pin_out)
        else $error("pin not low after match");
    AST_MATCH_HIGH: assert property (s_match(2'h2) |=> ch1_b_pin_out)
        else $error("pin not high after match");
    AST_MATCH_TOGGLE: assert property (s_match(2'h3)
        |=> ch1_b_pin_out != $past(ch1_b_pin_out))
        else $error("pin did not toggle on match");
    AST_MATCH_RETAIN: assert property (s_match(2'h0) |=> $stable(ch1_b_pin_out))
        else $error("pin changed with retain action");
    AST_INIT_LEVEL: assert property (io_wr && !wb_req.dat[7] && wb_req.dat[5:4] != 2'h0
        |=> ch1_b_pin_out == $past(wb_req.dat[6]) && !ch1_b_pin_oe_n)
        else $error("initial level not applied");
    AST_CAP_RISE: assert property (pin_rise && st_reg.io_ctl[7:4] == 4'h8
        |=> st_reg.grb == $past(counter_value))
        else $error("rising edge not captured");
    AST_CAP_FALL: assert property (pin_fall && st_reg.io_ctl[7:4] == 4'h9
        |=> st_reg.grb == $past(counter_value))
        else $error("falling edge not captured");
    AST_CAP_BOTH: assert property ((pin_rise || pin_fall) && st_reg.io_ctl[7:5] == 3'h5
        |=> st_reg.grb == $past(counter_value))
        else $error("edge not captured in both-edge mode");
    AST_CAP_CH0: assert property (ch0_c_event && st_reg.io_ctl[7:6] == 2'h3
        |=> st_reg.grb == $past(counter_value))
        else $error("channel-0 event not captured");
    AST_REQ_A: assert property (st_reg.status[0] && st_reg.irq_en[0] |=> irq_req_a)
        else $error("request A not raised");
    AST_REQ_A_GATE: assert property (!(st_reg.status[0] && st_reg.irq_en[0])
        |=> !irq_req_a)
        else $error("request A raised while gated");
    AST_REQ_B: assert property (!st_reg.status[1] || !st_reg.irq_en[1] |=> !irq_req_b)
        else $error("request B raised while gated");
    AST_REQ_B_SET: assert property (st_reg.status[1] && st_reg.irq_en[1] |=> irq_req_b)
        else $error("request B not raised");
    AST_REQ_C: assert property (!irq_req_c)
        else $error("request C raised");
    AST_RSV_READ: assert property (bus_acc && !wb_req.we &&
        wb_req.adr == ch1_timer_pkg::IRQ_EN_OFS |=> wb_rsp.dat[2] == 1'b0)
        else $error("reserved enable bit seen");
    AST_FLAG_B: assert property ((s_cap_cfg(st_reg.io_ctl[7:4]) or s_match(oc_act))
        |=> st_reg.status[1])
        else $error("flag B not set by event");
endmodule // ch1_b_channel

// >>> test/pin_ext.sv
// Outside source wired to the channel pin
`timescale 1ns/1ns
module pin_ext (
    // Pad control from the channel
    input wire logic pin_out,
    input wire logic pin_oe_n,
    // Level the outside source puts on the pad
    input wire logic src_level,
    // Resolved pad level
    output logic pin_in
);
    // No pull on this pad, so the outside source owns it whenever the channel lets go
    assign pin_in = pin_oe_n ? src_level : pin_out;
endmodule // pin_ext

// >>> test/tb_top.sv
// Self-checking bench of the channel-1 B compare/capture block
`timescale 1ns/1ns
module tb_top;
    logic mclk;
    logic rst_n;
    ch1_timer_pkg::wb_req_t req;
    ch1_timer_pkg::wb_rsp_t rsp;
    logic [15:0] cnt;
    logic c0_ev, a_ev, lvl, pin_in, pin_out, pin_oe_n, irq, req_a, req_b, req_c;
    int n_mismatch, tests_run;
    logic [31:0] seed, q;
    logic [15:0] exp_grb;
    logic exp_pin;

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ch1_b_channel dut_u (.mclk(mclk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
        .counter_value(cnt), .ch0_c_event(c0_ev), .flag_a_event(a_ev),
        .ch1_b_pin_in(pin_in), .ch1_b_pin_out(pin_out), .ch1_b_pin_oe_n(pin_oe_n),
        .irq(irq), .irq_req_a(req_a), .irq_req_b(req_b), .irq_req_c(req_c));

    pin_ext pad_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_level(lvl), .pin_in(pin_in));

    // Xorshift source, repeatable from the fixed start value
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Counts, verdict and end of run
    task results();
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Classic single cycle; read data lands in q at the ack edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (rsp.ack !== 1'b1 && i < 20);
        q = rsp.dat;
        req <= '0;
        @(posedge mclk);
        if (i >= 20) begin
            n_mismatch++;
            results();
        end
    endtask

    // Main sequence
    initial begin
        seed = 32'h5;
        n_mismatch = 0;
        tests_run = 0;
        rst_n = 1'b0;
        req = '0;
        cnt = 16'h0;
        c0_ev = 1'b0;
        a_ev = 1'b0;
        lvl = 1'b0;
        exp_pin = 1'b0;
        wait_n(8);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("pin_out", 32'h0, {31'h0, pin_out});
        chk("pin_oe_n", 32'h0, {31'h0, pin_oe_n});
        wb(1'b0, ch1_timer_pkg::IO_CTL_OFS, 32'h0);
        chk("io_ctl", 32'h0, q);
        wb(1'b0, ch1_timer_pkg::GRB_OFS, 32'h0);
        chk("grb", 32'h0000FFFF, q);
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b0, ch1_timer_pkg::IRQ_EN_OFS, 32'h0);
        chk("irq_en", 32'h0, q);
        wb(1'b1, ch1_timer_pkg::IRQ_EN_OFS, 32'h7);
        wb(1'b0, ch1_timer_pkg::IRQ_EN_OFS, 32'h0);
        chk("irq_en", 32'h3, q);
        // Flag A with its enable off must stay silent, then show once enabled
        wb(1'b1, ch1_timer_pkg::IRQ_EN_OFS, 32'h2);
        a_ev <= 1'b1;
        @(posedge mclk);
        a_ev <= 1'b0;
        wait_n(3);
        chk("req_a", 32'h0, {31'h0, req_a});
        chk("irq", 32'h0, {31'h0, irq});
        wb(1'b1, ch1_timer_pkg::IRQ_EN_OFS, 32'h3);
        wait_n(2);
        chk("req_a", 32'h1, {31'h0, req_a});
        wb(1'b1, ch1_timer_pkg::MASK_OFS, 32'h1);
        wait_n(2);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, ch1_timer_pkg::STATUS_OFS, 32'h1);
        wait_n(2);
        chk("req_a", 32'h0, {31'h0, req_a});
        chk("irq", 32'h0, {31'h0, irq});
        chk("req_c", 32'h0, {31'h0, req_c});
        // Every compare action, two matches each so toggling shows twice
        for (int f = 0; f < 8; f++) begin
            wb(1'b1, ch1_timer_pkg::IO_CTL_OFS, {24'h0, 1'b0, 3'(f), 4'h0});
            wait_n(1);
            if (f[1:0] != 2'h0) exp_pin = f[2];
            chk("pin init", {31'h0, exp_pin}, {31'h0, pin_out});
            exp_grb = 16'(rnd()) | 16'h1;
            wb(1'b1, ch1_timer_pkg::GRB_OFS, {16'h0, exp_grb});
            repeat (2) begin
                cnt <= exp_grb;
                wait_n(3);
                if (f[1:0] == 2'h1) exp_pin = 1'b0;
                if (f[1:0] == 2'h2) exp_pin = 1'b1;
                if (f[1:0] == 2'h3) exp_pin = ~exp_pin;
                chk("pin match", {31'h0, exp_pin}, {31'h0, pin_out});
                chk("req_b", 32'h1, {31'h0, req_b});
                cnt <= 16'h0;
                wb(1'b1, ch1_timer_pkg::STATUS_OFS, 32'h2);
                wait_n(1);
                chk("req_b", 32'h0, {31'h0, req_b});
            end
        end
        // Capture selections; pin starts high so the first edge falls
        for (int m = 8; m < 16; m++) begin
            wb(1'b1, ch1_timer_pkg::IO_CTL_OFS, 32'h60);
            lvl <= 1'b1;
            wait_n(4);
            wb(1'b1, ch1_timer_pkg::IO_CTL_OFS, {24'h0, 4'(m), 4'h0});
            wait_n(4);
            chk("oe_n cap", 32'h1, {31'h0, pin_oe_n});
            for (int e = 0; e < 2; e++) begin
                cnt <= 16'(rnd());
                lvl <= e[0];
                wait_n(8);
                if ((m == 8 && e == 1) || (m == 9 && e == 0) || m == 10 || m == 11) exp_grb = cnt;
                wb(1'b0, ch1_timer_pkg::GRB_OFS, 32'h0);
                chk("grb cap", {16'h0, exp_grb}, q);
            end
            if (m >= 12) begin
                cnt <= 16'(rnd());
                c0_ev <= 1'b1;
                @(posedge mclk);
                c0_ev <= 1'b0;
                wait_n(3);
                exp_grb = cnt;
                wb(1'b0, ch1_timer_pkg::GRB_OFS, 32'h0);
                chk("grb ch0", {16'h0, exp_grb}, q);
            end
        end
        results();
    end
endmodule // tb_top
